// >>> rtl/bcd_top.sv
// Battery charge detect control: upstream detection, status pins, downstream roles.
`timescale 1ns/1ps
`include "bcd_regs.svh"
// ==========================================================
module bcd_top #(
	parameter int NUM_PORTS = 3,
	parameter int TICK_CYCLES = `BCD_TICK_CYCLES,
	parameter int SETTLE_CYCLES = `BCD_SETTLE_CYCLES
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [2:0] hub_stage_in,
	input wire logic detect_enable_in,
	input wire logic enhanced_detect_enable_in,
	input wire logic detect_in_clock_wait_in,
	input wire logic upstream_hsic_in,
	input wire logic dp_dm_short_in,
	input wire logic dm_reflects_dp_in,
	input wire logic dp_pulldown_in,
	input wire logic dm_pulldown_in,
	input wire logic dp_at_2v7_in,
	input wire logic dp_at_2v0_in,
	input wire logic dm_at_2v7_in,
	input wire logic dm_at_2v0_in,
	input wire logic custom_load_in,
	input wire logic [2:0] custom_type_in,
	input wire logic [7:0] charger_mask_in,
	input wire logic [1:0] status_pin_enable_in,
	input wire logic vbus_detect_in,
	input wire logic configured_in,
	input wire logic init_done_in,
	input wire logic host_connected_in,
	input wire logic supply_present_cfg_in,
	input wire logic [NUM_PORTS:0] charge_enable_in,
	input wire logic [NUM_PORTS:0] port_hsic_in,
	input wire logic [NUM_PORTS:0] overcurrent_sense_in,
	input wire logic [NUM_PORTS:0] host_port_power_in,
	input wire logic [17:0] tick_terminal_in,
	output logic [2:0] charger_type_out,
	output logic detect_done_out,
	output logic [1:0] charger_status_field_out,
	output logic [1:0] charger_status_pins_out,
	output logic [NUM_PORTS:0] port_power_bits_out,
	output logic [NUM_PORTS:0] port_power_out,
	output logic [NUM_PORTS:0] port_dcp_out,
	output logic [NUM_PORTS:0] port_cdp_out,
	output logic charge_supply_indicator_out
);
	// ==========================================================
	// Elaboration checks
	if (NUM_PORTS < 1 || NUM_PORTS > 7) begin : g_bad_ports
		$error("NUM_PORTS must be 1 to 7");
	end
	if (TICK_CYCLES < 2 || TICK_CYCLES > 262143) begin : g_bad_tick
		$error("TICK_CYCLES must fit 18 bits");
	end
	if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin : g_bad_settle
		$error("SETTLE_CYCLES must fit 16 bits");
	end

	// ==========================================================
	// Line decoder hookup
	bcd_line_if line (); // Comparator levels to the decoder
	assign line.dp_dm_short = dp_dm_short_in;
	assign line.dm_reflects_dp = dm_reflects_dp_in;
	assign line.dp_pulldown = dp_pulldown_in;
	assign line.dm_pulldown = dm_pulldown_in;
	assign line.dp_at_2v7 = dp_at_2v7_in;
	assign line.dp_at_2v0 = dp_at_2v0_in;
	assign line.dm_at_2v7 = dm_at_2v7_in;
	assign line.dm_at_2v0 = dm_at_2v0_in;
	assign line.enhanced = enhanced_detect_enable_in;

	bcd_classify u_classify (
		.line(line)
	);

	// ==========================================================
	// Detection sequencer state
	bcd_pkg::bcd_det_state_e det_reg, det_next; // Sequencer
	logic [15:0] settle_reg, settle_next; // Settle counter
	bcd_pkg::bcd_type_t type_reg, type_next; // Reported charger type
	logic done_reg, done_next; // A result is held
	logic start_ok; // Conditions to run detection

	// Detect stage, or clock wait stage when allowed; never over HSIC
	assign start_ok = detect_enable_in && !upstream_hsic_in &&
		(hub_stage_in == `BCD_STAGE_DETECT ||
		(hub_stage_in == `BCD_STAGE_CLOCK_WAIT && detect_in_clock_wait_in));

	// ==========================================================
	// Detection next state
	// The decoder is sampled only after the lines have settled
	always_comb begin
		det_next = det_reg;
		settle_next = settle_reg;
		type_next = type_reg;
		done_next = done_reg;
		case (det_reg)
			bcd_pkg::DET_IDLE: begin
				settle_next = 16'h0000;
				if (start_ok) begin
					det_next = bcd_pkg::DET_SETTLE;
				end
			end
			bcd_pkg::DET_SETTLE: begin
				if (!start_ok) begin
					// Stage left before a result: abandon quietly
					det_next = bcd_pkg::DET_IDLE;
				end else if (settle_reg == 16'(SETTLE_CYCLES - 1)) begin
					det_next = bcd_pkg::DET_DONE;
					type_next = line.type_code;
					done_next = 1'b1;
				end else begin
					settle_next = settle_reg + 16'h0001;
				end
			end
			bcd_pkg::DET_DONE: begin
				// Result held until detection is turned off or link is HSIC
				if (!detect_enable_in || upstream_hsic_in) begin
					det_next = bcd_pkg::DET_IDLE;
					type_next = `BCD_TYPE_NONE;
					done_next = 1'b0;
				end
			end
			default: begin
				det_next = bcd_pkg::DET_IDLE;
			end
		endcase
		// Software load is never blocked; timing is software's duty
		if (custom_load_in) begin
			type_next = custom_type_in;
			done_next = 1'b1;
		end
	end

	// ==========================================================
	// Detection registers
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			det_reg <= bcd_pkg::DET_IDLE;
			settle_reg <= 16'h0000;
			type_reg <= `BCD_TYPE_NONE;
			done_reg <= 1'b0;
		end else begin
			det_reg <= det_next;
			settle_reg <= settle_next;
			type_reg <= type_next;
			done_reg <= done_next;
		end
	end

	// ==========================================================
	// Charger status state
	logic [1:0] field_reg, field_next; // Status field
	logic [1:0] pins_reg, pins_next; // Status pins
	logic charger_hit; // Selected charger found

	// Charger found beats configured beats bus power
	always_comb begin
		charger_hit = done_reg && type_reg != `BCD_TYPE_NONE && charger_mask_in[type_reg];
		if (charger_hit) begin
			field_next = `BCD_STAT_CHARGER;
		end else if (configured_in) begin
			field_next = `BCD_STAT_CFG;
		end else if (vbus_detect_in) begin
			field_next = `BCD_STAT_UNCFG;
		end else begin
			field_next = `BCD_STAT_NONE;
		end
		// A disabled pin sits low so one pin can be used alone
		pins_next = field_next & status_pin_enable_in;
	end

	// ==========================================================
	// Status registers
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			field_reg <= `BCD_STAT_NONE;
			pins_reg <= 2'h0;
		end else begin
			field_reg <= field_next;
			pins_reg <= pins_next;
		end
	end

	// ==========================================================
	// Millisecond tick state
	logic [17:0] tick_reg, tick_next; // Cycle counter
	logic tick_pulse_reg, tick_pulse_next; // One-cycle ms tick
	logic [17:0] terminal; // Active terminal count

	// Zero on the terminal input means use the built-in default
	always_comb begin
		terminal = (tick_terminal_in == 18'h00000) ? 18'(TICK_CYCLES) : tick_terminal_in;
		tick_pulse_next = 1'b0;
		if (tick_reg + 18'h00001 >= terminal) begin
			tick_next = 18'h00000;
			tick_pulse_next = 1'b1;
		end else begin
			tick_next = tick_reg + 18'h00001;
		end
	end

	// ==========================================================
	// Tick registers
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			tick_reg <= 18'h00000;
			tick_pulse_reg <= 1'b0;
		end else begin
			tick_reg <= tick_next;
			tick_pulse_reg <= tick_pulse_next;
		end
	end

	// ==========================================================
	// Downstream role state
	logic locked_reg, locked_next; // Charging set frozen
	logic [NUM_PORTS:0] charge_reg, charge_next; // Charging ports
	logic [NUM_PORTS:0] dcp_reg, dcp_next; // DCP role
	logic [NUM_PORTS:0] cdp_reg, cdp_next; // CDP role
	logic supply_reg, supply_next; // Supply indicator

	// Charging set is captured once; only CDP/DCP may swap after
	always_comb begin
		locked_next = locked_reg;
		charge_next = charge_reg;
		if (init_done_in && !locked_reg) begin
			locked_next = 1'b1;
			// Bit 0 has no port; HSIC ports never charge
			charge_next = charge_enable_in & ~port_hsic_in;
			charge_next[0] = 1'b0;
		end
		// Host presence picks CDP or DCP for charging ports
		cdp_next = host_connected_in ? charge_next : '0;
		dcp_next = host_connected_in ? '0 : charge_next;
		supply_next = supply_present_cfg_in && locked_next && (|charge_next);
	end

	// ==========================================================
	// Role registers
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			locked_reg <= 1'b0;
			charge_reg <= '0;
			dcp_reg <= '0;
			cdp_reg <= '0;
			supply_reg <= 1'b0;
		end else begin
			locked_reg <= locked_next;
			charge_reg <= charge_next;
			dcp_reg <= dcp_next;
			cdp_reg <= cdp_next;
			supply_reg <= supply_next;
		end
	end

	// ==========================================================
	// Per-port power and retry
	assign port_power_out[0] = 1'b0; // No port zero
	for (genvar i = 1; i <= NUM_PORTS; i++) begin : g_port
		bcd_pkg::bcd_role_e role; // Role handed to the sequencer
		assign role = dcp_reg[i] ? bcd_pkg::ROLE_DCP :
			(cdp_reg[i] ? bcd_pkg::ROLE_CDP : bcd_pkg::ROLE_SDP);
		bcd_retry u_retry (
			.clk_in(clk_in),
			.reset_in(reset_in),
			.ms_tick_in(tick_pulse_reg),
			.role_in(role),
			.init_done_in(locked_reg),
			.overcurrent_in(overcurrent_sense_in[i]),
			.host_power_in(host_port_power_in[i]),
			.power_out(port_power_out[i])
		);
	end

	// ==========================================================
	// Outputs
	assign charger_type_out = type_reg;
	assign detect_done_out = done_reg;
	assign charger_status_field_out = field_reg;
	assign charger_status_pins_out = pins_reg;
	assign port_power_bits_out = charge_reg;
	assign port_dcp_out = dcp_reg;
	assign port_cdp_out = cdp_reg;
	assign charge_supply_indicator_out = supply_reg;
endmodule

// >>> rtl/bcd_regs.svh
// Constants for the battery charge detect control block.
`ifndef BCD_REGS_SVH
`define BCD_REGS_SVH
// ==========================================================
// Clock
`define BCD_CLK_PERIOD_PS 5000
// ==========================================================
// Upstream charger type codes
`define BCD_TYPE_NONE 3'h0
`define BCD_TYPE_DCP 3'h1
`define BCD_TYPE_CDP 3'h2
`define BCD_TYPE_SDP 3'h3
`define BCD_TYPE_LOW 3'h4
`define BCD_TYPE_HIGH 3'h5
`define BCD_TYPE_SUPER 3'h6
// ==========================================================
// Charger status field codes
`define BCD_STAT_NONE 2'h0
`define BCD_STAT_UNCFG 2'h1
`define BCD_STAT_CFG 2'h2
`define BCD_STAT_CHARGER 2'h3
// ==========================================================
// Hub stage codes on the stage input
`define BCD_STAGE_CLOCK_WAIT 3'h1
`define BCD_STAGE_DETECT 3'h2
// ==========================================================
// Timing
`define BCD_SETTLE_NS 1000
`define BCD_SETTLE_CYCLES ((`BCD_SETTLE_NS * 1000 + `BCD_CLK_PERIOD_PS - 1) / `BCD_CLK_PERIOD_PS)
`define BCD_TICK_NS 1000000
`define BCD_TICK_CYCLES (`BCD_TICK_NS * 1000 / `BCD_CLK_PERIOD_PS)
`define BCD_MS_PER_S 1000
`define BCD_RETRY_SHORT_S 1
`define BCD_RETRY_LONG_S 10
`define BCD_RETRY_SHORT_MS 14'(`BCD_RETRY_SHORT_S * `BCD_MS_PER_S)
`define BCD_RETRY_LONG_MS 14'(`BCD_RETRY_LONG_S * `BCD_MS_PER_S)
`define BCD_RETRY_FAST_TRIES 2'h3
`endif

// >>> rtl/bcd_pkg.sv
// Types shared by the battery charge detect control modules.
package bcd_pkg;
	// ==========================================================
	// Upstream detection sequencer
	typedef enum logic [1:0] {DET_IDLE, DET_SETTLE, DET_DONE} bcd_det_state_e;
	// Downstream port role
	typedef enum logic [1:0] {ROLE_SDP, ROLE_CDP, ROLE_DCP} bcd_role_e;
	// Over-current retry sequencer
	typedef enum logic [1:0] {PWR_OFF, PWR_ON, PWR_BACKOFF} bcd_pwr_state_e;
	// Charger type code
	typedef logic [2:0] bcd_type_t;
endpackage

// >>> rtl/bcd_line_if.sv
// Upstream line comparator levels and the decoded charger type.
`timescale 1ns/1ps
interface bcd_line_if;
	logic dp_dm_short; // Data lines shorted together
	logic dm_reflects_dp; // D+ level mirrored on D-
	logic dp_pulldown; // Host pull-down on D+
	logic dm_pulldown; // Host pull-down on D-
	logic dp_at_2v7; // D+ near 2.7 V
	logic dp_at_2v0; // D+ near 2.0 V
	logic dm_at_2v7; // D- near 2.7 V
	logic dm_at_2v0; // D- near 2.0 V
	logic enhanced; // Enhanced detection setting
	bcd_pkg::bcd_type_t type_code; // Decoded type
	modport src (output dp_dm_short, dm_reflects_dp, dp_pulldown, dm_pulldown,
		dp_at_2v7, dp_at_2v0, dm_at_2v7, dm_at_2v0, enhanced, input type_code);
	modport cls (input dp_dm_short, dm_reflects_dp, dp_pulldown, dm_pulldown,
		dp_at_2v7, dp_at_2v0, dm_at_2v7, dm_at_2v0, enhanced, output type_code);
endinterface

// >>> rtl/bcd_classify.sv
// Combinational upstream charger type decoder.
`timescale 1ns/1ps
`include "bcd_regs.svh"
module bcd_classify (
	bcd_line_if.cls line
);
	// ==========================================================
	// Decoder
	// Short wins over everything, since a shorted pair also looks reflected
	function automatic bcd_pkg::bcd_type_t classify(
		input logic sh, input logic refl, input logic en,
		input logic pd_p, input logic pd_m,
		input logic p27, input logic p20, input logic m27, input logic m20);
		bcd_pkg::bcd_type_t t;
		t = `BCD_TYPE_NONE;
		if (sh) begin
			t = `BCD_TYPE_DCP;
		end else if (refl && en) begin
			t = `BCD_TYPE_CDP;
		end else if (p27 && m20) begin
			t = `BCD_TYPE_SUPER;
		end else if (p20 && m20) begin
			t = `BCD_TYPE_LOW;
		end else if (p20 && m27) begin
			t = `BCD_TYPE_HIGH;
		end else if (pd_p && pd_m) begin
			t = `BCD_TYPE_SDP;
		end
		return t;
	endfunction

	// Result is pure decode; the top samples it after settling
	assign line.type_code = classify(line.dp_dm_short, line.dm_reflects_dp, line.enhanced,
		line.dp_pulldown, line.dm_pulldown, line.dp_at_2v7, line.dp_at_2v0,
		line.dm_at_2v7, line.dm_at_2v0);
endmodule

// >>> rtl/bcd_retry.sv
// Per-port power enable with over-current back-off timing.
`timescale 1ns/1ps
`include "bcd_regs.svh"
module bcd_retry (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic ms_tick_in,
	input wire bcd_pkg::bcd_role_e role_in,
	input wire logic init_done_in,
	input wire logic overcurrent_in,
	input wire logic host_power_in,
	output logic power_out
);
	// ==========================================================
	// State
	bcd_pkg::bcd_pwr_state_e state_reg, state_next; // Sequencer
	logic [13:0] ms_reg, ms_next; // Back-off elapsed ms
	logic [1:0] tries_reg, tries_next; // Retries so far, saturating
	logic power_reg, power_next; // Registered power output
	logic [13:0] limit; // Current back-off length

	// ==========================================================
	// Next state
	always_comb begin
		state_next = state_reg;
		ms_next = ms_reg;
		tries_next = tries_reg;
		// Short back-off for the first attempts, long one after until the port leaves DCP
		limit = (tries_reg < `BCD_RETRY_FAST_TRIES) ? `BCD_RETRY_SHORT_MS : `BCD_RETRY_LONG_MS;
		case (state_reg)
			bcd_pkg::PWR_OFF: begin
				tries_next = 2'h0;
				// DCP port powers up once init is finished
				if (init_done_in && role_in == bcd_pkg::ROLE_DCP) begin
					state_next = bcd_pkg::PWR_ON;
				end
			end
			bcd_pkg::PWR_ON: begin
				if (role_in != bcd_pkg::ROLE_DCP) begin
					state_next = bcd_pkg::PWR_OFF;
				end else if (overcurrent_in) begin
					state_next = bcd_pkg::PWR_BACKOFF;
					ms_next = 14'h0000;
				end
			end
			bcd_pkg::PWR_BACKOFF: begin
				if (role_in != bcd_pkg::ROLE_DCP) begin
					state_next = bcd_pkg::PWR_OFF;
				end else if (ms_tick_in) begin
					if (ms_reg + 14'h0001 >= limit) begin
						// Re-enable; a persisting fault trips again
						state_next = bcd_pkg::PWR_ON;
						if (tries_reg != `BCD_RETRY_FAST_TRIES) begin
							tries_next = tries_reg + 2'h1;
						end
					end else begin
						ms_next = ms_reg + 14'h0001;
					end
				end
			end
			default: begin
				state_next = bcd_pkg::PWR_OFF;
			end
		endcase
		// Outside DCP the host owns port power; fault only gates charging ports
		case (role_in)
			bcd_pkg::ROLE_DCP: power_next = (state_next == bcd_pkg::PWR_ON) && !overcurrent_in;
			bcd_pkg::ROLE_CDP: power_next = host_power_in && !overcurrent_in;
			default: power_next = host_power_in;
		endcase
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_reg <= bcd_pkg::PWR_OFF;
			ms_reg <= 14'h0000;
			tries_reg <= 2'h0;
			power_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ms_reg <= ms_next;
			tries_reg <= tries_next;
			power_reg <= power_next;
		end
	end

	assign power_out = power_reg;
endmodule

// >>> bench/bcd_charger_model.sv
// Far-side model: upstream charger turned into comparator levels.
`timescale 1ns/1ps
module bcd_charger_model (
	input wire logic [2:0] kind_in,
	output logic [7:0] lines_out
);
	// ==========================================================
	// Profiles
	// Order: short, reflect, dp pull-down, dm pull-down, dp 2.7, dp 2.0, dm 2.7, dm 2.0
	// Kind numbers equal the codes the hub should report, to keep the bench simple
	always_comb begin
		case (kind_in)
			3'h1: lines_out = 8'h80; // Shorted data lines
			3'h2: lines_out = 8'h40; // D+ mirrored on D
			3'h3: lines_out = 8'h30; // Host pull-downs on both
			3'h4: lines_out = 8'h05; // Both lines near 2.0 V
			3'h5: lines_out = 8'h06; // D+ 2.0 V, D- 2.7 V
			3'h6: lines_out = 8'h09; // D+ 2.7 V, D- 2.0 V
			default: lines_out = 8'h00; // Nothing attached
		endcase
	end
endmodule

// >>> bench/bcd_checker.sv
// Port-level assertions for the charge detect control top.
`timescale 1ns/1ps
module bcd_checker #(
	parameter int NUM_PORTS = 3,
	parameter int SETTLE_CYCLES = 4
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [2:0] hub_stage_in,
	input wire logic detect_enable_in,
	input wire logic detect_in_clock_wait_in,
	input wire logic upstream_hsic_in,
	input wire logic [7:0] charger_mask_in,
	input wire logic [1:0] status_pin_enable_in,
	input wire logic vbus_detect_in,
	input wire logic configured_in,
	input wire logic host_connected_in,
	input wire logic [NUM_PORTS:0] overcurrent_sense_in,
	input wire logic [NUM_PORTS:0] host_port_power_in,
	input wire logic [2:0] charger_type_out,
	input wire logic detect_done_out,
	input wire logic [1:0] charger_status_field_out,
	input wire logic [1:0] charger_status_pins_out,
	input wire logic [NUM_PORTS:0] port_power_bits_out,
	input wire logic [NUM_PORTS:0] port_power_out,
	input wire logic [NUM_PORTS:0] port_dcp_out,
	input wire logic [NUM_PORTS:0] port_cdp_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// ==========================================================
	// Helpers
	logic start_ok; // Detection allowed this cycle
	logic hit; // Held result selected by the mask
	logic [7:0] run_reg, run_next; // Unbroken cycles of start_ok, saturating
	assign start_ok = detect_enable_in && !upstream_hsic_in &&
		(hub_stage_in == 3'h2 || (hub_stage_in == 3'h1 && detect_in_clock_wait_in));
	assign hit = detect_done_out && charger_type_out != 3'h0 && charger_mask_in[charger_type_out];
	// Any gap restarts the count, as a gap aborts detection
	always_comb run_next = !start_ok ? 8'h00 : (run_reg == 8'hFF ? run_reg : run_reg + 8'h01);
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			run_reg <= 8'h00;
		end else begin
			run_reg <= run_next;
		end
	end
	// ==========================================================
	// Checks
	detect_latency_a: assert property (run_reg > SETTLE_CYCLES + 1 |-> detect_done_out)
		else $error("detection result late");
	detect_clear_a: assert property (!detect_enable_in || upstream_hsic_in |=> !detect_done_out)
		else $error("detection result not cleared");
	status_charger_a: assert property (hit |=> charger_status_field_out == 2'h3)
		else $error("charger status not 11");
	status_config_a: assert property (!hit && configured_in |=> charger_status_field_out == 2'h2)
		else $error("configured status not 10");
	status_vbus_a: assert property (!hit && !configured_in && vbus_detect_in |=> charger_status_field_out == 2'h1)
		else $error("bus power status not 01");
	status_idle_a: assert property (!hit && !configured_in && !vbus_detect_in |=> charger_status_field_out == 2'h0)
		else $error("idle status not 00");
	pins_follow_a: assert property (charger_status_pins_out == (charger_status_field_out & $past(status_pin_enable_in)))
		else $error("status pins differ from field");
	set_frozen_a: assert property (port_power_bits_out != '0 |=> $stable(port_power_bits_out))
		else $error("charging set changed");
	role_split_a: assert property ($stable(port_power_bits_out) && $stable(host_connected_in) |->
		port_cdp_out == (host_connected_in ? port_power_bits_out : '0) &&
		port_dcp_out == (host_connected_in ? '0 : port_power_bits_out))
		else $error("port role mismatch");
	fault_off_a: assert property ((port_power_out & $past(overcurrent_sense_in & port_power_bits_out)) == '0)
		else $error("charging port powered during fault");
	sdp_host_a: assert property ($past(port_power_bits_out) != '0 |->
		(port_power_out & ~port_power_bits_out) ==
		($past(host_port_power_in) & ~port_power_bits_out & ~(NUM_PORTS + 1)'(1)))
		else $error("standard port power not host driven");
	port_zero_a: assert property (!port_power_out[0] && !port_power_bits_out[0])
		else $error("unused bit 0 set");
endmodule
bind bcd_top bcd_checker #(.NUM_PORTS(NUM_PORTS), .SETTLE_CYCLES(SETTLE_CYCLES)) chk (
	.clk_in(clk_in), .reset_in(reset_in), .hub_stage_in(hub_stage_in), .detect_enable_in(detect_enable_in),
	.detect_in_clock_wait_in(detect_in_clock_wait_in), .upstream_hsic_in(upstream_hsic_in),
	.charger_mask_in(charger_mask_in), .status_pin_enable_in(status_pin_enable_in),
	.vbus_detect_in(vbus_detect_in), .configured_in(configured_in), .host_connected_in(host_connected_in),
	.overcurrent_sense_in(overcurrent_sense_in), .host_port_power_in(host_port_power_in),
	.charger_type_out(charger_type_out), .detect_done_out(detect_done_out),
	.charger_status_field_out(charger_status_field_out), .charger_status_pins_out(charger_status_pins_out),
	.port_power_bits_out(port_power_bits_out), .port_power_out(port_power_out),
	.port_dcp_out(port_dcp_out), .port_cdp_out(port_cdp_out));

// >>> bench/tb_bcd_top.sv
// Self-checking bench for the charge detect control top.
`timescale 1ns/1ps
module tb_bcd_top;
	// ==========================================================
	// Settings and signals
	localparam int NP = 3; // Downstream ports
	localparam int ST = 4; // Short settle count keeps runs brief
	localparam int TK = 4; // Cycles per ms tick
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [2:0] stage = 3'h0, kind = 3'h0, ctype = 3'h0;
	logic den = 1'b0, enh = 1'b0, cw = 1'b0, hsic = 1'b0, cload = 1'b0;
	logic vbus = 1'b0, cfg = 1'b0, idone = 1'b0, host = 1'b0, sup = 1'b0;
	logic [7:0] lines, mask = 8'h00;
	logic [1:0] pen = 2'h0, fld_o, pin_o;
	logic [NP:0] cen = '0, phs = '0, oc = '0, hpw = '0, pbits_o, pwr_o, dcp_o, cdp_o;
	logic [2:0] type_o;
	logic done_o, ind_o;
	int num_errors = 0, n_tests = 0, seed = 57110, n, exp_t, exp_s;
	int exp_off[$] = {1000 * TK, 1000 * TK, 1000 * TK, 10000 * TK}; // Off times in cycles
	// Free-running clock
	always #2.5 clk_in = ~clk_in;
	bcd_charger_model PM (.kind_in(kind), .lines_out(lines));
	bcd_top #(.NUM_PORTS(NP), .SETTLE_CYCLES(ST)) DUT (.clk_in(clk_in), .reset_in(reset_in),
		.hub_stage_in(stage), .detect_enable_in(den), .enhanced_detect_enable_in(enh),
		.detect_in_clock_wait_in(cw), .upstream_hsic_in(hsic), .dp_dm_short_in(lines[7]),
		.dm_reflects_dp_in(lines[6]), .dp_pulldown_in(lines[5]), .dm_pulldown_in(lines[4]),
		.dp_at_2v7_in(lines[3]), .dp_at_2v0_in(lines[2]), .dm_at_2v7_in(lines[1]), .dm_at_2v0_in(lines[0]),
		.custom_load_in(cload), .custom_type_in(ctype), .charger_mask_in(mask), .status_pin_enable_in(pen),
		.vbus_detect_in(vbus), .configured_in(cfg), .init_done_in(idone), .host_connected_in(host),
		.supply_present_cfg_in(sup), .charge_enable_in(cen), .port_hsic_in(phs), .overcurrent_sense_in(oc),
		.host_port_power_in(hpw), .tick_terminal_in(18'(TK)), .charger_type_out(type_o),
		.detect_done_out(done_o), .charger_status_field_out(fld_o), .charger_status_pins_out(pin_o),
		.port_power_bits_out(pbits_o), .port_power_out(pwr_o), .port_dcp_out(dcp_o), .port_cdp_out(cdp_o),
		.charge_supply_indicator_out(ind_o));
	// ==========================================================
	// Helpers
	// Compare and count; wide args keep unknowns visible
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (exp !== got) begin
			num_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// Counts, verdict and end of run
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Inputs only move at falling edges
	task automatic cyc(input int k);
		repeat (k) @(negedge clk_in);
	endtask
	// Bounded wait for port 1 power; a hang ends the run
	task automatic wait_pwr(output int t);
		t = 0;
		while (pwr_o[1] !== 1'b1) begin
			t++;
			cyc(1);
			if (t > 50000) begin
				num_errors++;
				$display("CHECK FAILED power return expected 1 seen %0h", pwr_o[1]);
				give_verdict();
			end
		end
	endtask
	// Reference decoder: kind equals code, reflect only counts when enhanced
	function automatic int m_type(input int k, input int e);
		if (k == 2) begin
			return e ? 2 : 0;
		end
		return k;
	endfunction
	// ==========================================================
	// Main sequence
	initial begin
		cyc(12);
		reset_in = 1'b0;
		cyc(2);
		// Every profile, stage and upstream mode; second round turns on enhanced detection
		for (int i = 0; i < 42; i++) begin
			den = 1'b0;
			cyc(2);
			kind = 3'(i % 7);
			stage = 3'(i % 3);
			hsic = 1'(i % 5 == 4);
			enh = 1'(i >= 21);
			cw = 1'($random(seed));
			mask = 8'($random(seed));
			pen = 2'($random(seed));
			cfg = 1'($random(seed));
			vbus = 1'($random(seed));
			den = 1'b1;
			cyc(ST + 4);
			n = (stage == 3'h2 || (stage == 3'h1 && cw)) && !hsic;
			exp_t = n ? m_type(i % 7, int'(enh)) : 0;
			exp_s = (n && exp_t != 0 && mask[exp_t]) ? 3 : (cfg ? 2 : (vbus ? 1 : 0));
			chk("done", n, done_o);
			chk("type", exp_t, type_o);
			chk("status", exp_s, fld_o);
			chk("pins", exp_s & int'(pen), pin_o);
		end
		$display("Test detection done");
		// Software load while in the configuration stage only
		stage = 3'h0;
		ctype = 3'h5;
		cload = 1'b1;
		cyc(1);
		cload = 1'b0;
		cyc(2);
		chk("custom type", 5, type_o);
		$display("Test custom load done");
		// Ports 1 and 2 charge, port 3 is HSIC and stays standard
		cen = 4'hE;
		phs = 4'h8;
		sup = 1'b1;
		hpw = 4'h8;
		cyc(2);
		idone = 1'b1;
		cyc(3);
		chk("power bits", 4'h6, pbits_o);
		chk("dcp roles", 4'h6, dcp_o);
		chk("supply flag", 1, ind_o);
		chk("port power", 4'hE, pwr_o);
		// Fault pulses on port 1: three short back-offs, then the long one
		foreach (exp_off[k]) begin
			oc = 4'h2;
			cyc(1);
			oc = 4'h0;
			wait_pwr(n);
			chk("off time", exp_off[k], (n > exp_off[k] - 3 * TK && n < exp_off[k] + 3 * TK) ? exp_off[k] : n);
		end
		// Host arrives; set must not follow later enable changes
		host = 1'b1;
		cen = 4'h0;
		hpw = 4'hE;
		oc = 4'h4;
		cyc(3);
		chk("cdp roles", 4'h6, cdp_o);
		chk("frozen bits", 4'h6, pbits_o);
		chk("host power", 4'hA, pwr_o);
		$display("Test downstream done");
		give_verdict();
	end
endmodule
